//--- design/dctom_map.svh
`ifndef DCTOM_MAP_SVH
`define DCTOM_MAP_SVH
// tolerated test pulse off time in microseconds
`define DCTOM_PULSE_MAX_US 1000
// clock rate in MHz
`define DCTOM_CLK_MHZ 25
// filter length: least time, so cycles = us * MHz, plus one cycle margin
`define DCTOM_FILT_CYCLES ((`DCTOM_PULSE_MAX_US * `DCTOM_CLK_MHZ) + 1)
// alarm code shown while the cutoff timing alarm stands
`define DCTOM_ALARM_CODE 8'h3F
`endif

//--- design/dctom_pkg.sv
package dctom_pkg;
  typedef struct packed {
    logic cut_a;
    logic cut_b;
  } dctom_cut_s;
  typedef enum logic [1:0] {
    DCTOM_RUN,
    DCTOM_CUT,
    DCTOM_ALARM
  } dctom_state_e;
endpackage : dctom_pkg

//--- design/dctom_monitor.sv
// Functional notes
// - open input a puts channel a into cutoff; closed input a allows release
// - open input b puts channel b into cutoff; closed input b allows release
// - monitor a is on while channel a is cut off, off when released
// - monitor b is on while channel b is cut off, off when released
// - power stage released only with both inputs closed
// - cutoff while motor runs gives dynamic brake stop and timing alarm
`timescale 1ns/10ps
`include "dctom_map.svh"
module dctom_monitor #(
  parameter int FILT_CYCLES = `DCTOM_FILT_CYCLES
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // safety inputs, high means closed to safety_input_common
  input wire logic safety_input_a,
  input wire logic safety_input_b,
  // motor state from the drive, high while the motor is operating
  input wire logic motor_running,
  // alarm reset request from the drive
  input wire logic alarm_clear,
  // monitor outputs, high means closed to cutoff_monitor_common
  output logic cutoff_monitor_a,
  output logic cutoff_monitor_b,
  // combined path across both monitors
  output logic cutoff_monitor_both,
  // base drive enable and brake
  output logic base_drive_enable,
  output logic dynamic_brake,
  output logic cutoff_timing_alarm,
  output logic [7:0] alarm_code
);
  localparam int CW = $clog2(FILT_CYCLES + 1);
  localparam logic [CW-1:0] FILT_MAX = CW'(FILT_CYCLES);

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers and off-pulse filters per channel
  logic [1:0] raw_in;
  logic [1:0] sync1;
  logic [1:0] sync2;
  logic [1:0] closed;
  dctom_pkg::dctom_cut_s cut;
  dctom_pkg::dctom_state_e state;
  dctom_pkg::dctom_state_e next_state;

  assign raw_in = {safety_input_a, safety_input_b};

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_chan
      logic [CW-1:0] off_cnt;
      wire cnt_done = (off_cnt == FILT_MAX);
      always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
          sync1[g] <= 1'b0;
          sync2[g] <= 1'b0;
          off_cnt <= '0;
          closed[g] <= 1'b0;
        end else begin
          sync1[g] <= raw_in[g];
          sync2[g] <= sync1[g];
          if (sync2[g]) begin
            off_cnt <= '0;
            closed[g] <= 1'b1;
          end else if (!cnt_done) begin
            off_cnt <= off_cnt + CW'(1);
          end else begin
            closed[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  assign cut.cut_a = ~closed[1];
  assign cut.cut_b = ~closed[0];

  ////////////////////////////////////////////////////////////////////////////
  // stop control
  wire any_cut = cut.cut_a | cut.cut_b;
  wire both_cut = cut.cut_a & cut.cut_b;

  always_comb begin
    next_state = state;
    unique case (state)
      dctom_pkg::DCTOM_RUN: begin
        if (any_cut && motor_running) begin
          next_state = dctom_pkg::DCTOM_ALARM;
        end else if (any_cut) begin
          next_state = dctom_pkg::DCTOM_CUT;
        end
      end
      dctom_pkg::DCTOM_CUT: begin
        if (!any_cut) begin
          next_state = dctom_pkg::DCTOM_RUN;
        end
      end
      dctom_pkg::DCTOM_ALARM: begin
        if (alarm_clear && !any_cut && !motor_running) begin
          next_state = dctom_pkg::DCTOM_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state <= dctom_pkg::DCTOM_CUT;
      cutoff_monitor_a <= 1'b1;
      cutoff_monitor_b <= 1'b1;
      cutoff_monitor_both <= 1'b1;
      base_drive_enable <= 1'b0;
      dynamic_brake <= 1'b0;
      cutoff_timing_alarm <= 1'b0;
      alarm_code <= 8'h00;
    end else begin
      state <= next_state;
      cutoff_monitor_a <= cut.cut_a;
      cutoff_monitor_b <= cut.cut_b;
      cutoff_monitor_both <= both_cut;
      base_drive_enable <= !any_cut && (next_state == dctom_pkg::DCTOM_RUN);
      dynamic_brake <= (next_state == dctom_pkg::DCTOM_ALARM) && motor_running;
      cutoff_timing_alarm <= (next_state == dctom_pkg::DCTOM_ALARM);
      alarm_code <= (next_state == dctom_pkg::DCTOM_ALARM) ? `DCTOM_ALARM_CODE : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  // helper: consecutive open samples per channel, saturating at the filter length
  genvar c;
  generate
    for (c = 0; c < 2; c++) begin : g_chk
      logic [CW-1:0] open_run;
      always_ff @(posedge clk_sys) begin
        if (sys_rst || sync2[c]) begin
          open_run <= '0;
        end else if (open_run != FILT_MAX) begin
          open_run <= open_run + CW'(1);
        end
      end
    end
  endgenerate
  property p_mon_a;
    @(posedge clk_sys) disable iff (sys_rst) 1'b1 |=> (cutoff_monitor_a == $past(cut.cut_a));
  endproperty
  a_mon_a: assert property (p_mon_a) else $error("monitor a wrong");
  property p_mon_b;
    @(posedge clk_sys) disable iff (sys_rst) 1'b1 |=> (cutoff_monitor_b == $past(cut.cut_b));
  endproperty
  a_mon_b: assert property (p_mon_b) else $error("monitor b wrong");
  property p_no_drive;
    @(posedge clk_sys) disable iff (sys_rst) (cutoff_monitor_a || cutoff_monitor_b) |-> !base_drive_enable;
  endproperty
  a_no_drive: assert property (p_no_drive) else $error("drive while cut");
  property p_both;
    @(posedge clk_sys) disable iff (sys_rst) cutoff_monitor_both == (cutoff_monitor_a && cutoff_monitor_b);
  endproperty
  a_both: assert property (p_both) else $error("combined monitor wrong");
  // input a open long enough cuts channel a
  property p_cut_a;
    @(posedge clk_sys) disable iff (sys_rst) (g_chk[1].open_run == FILT_MAX && !sync2[1]) |=> !closed[1];
  endproperty
  a_cut_a: assert property (p_cut_a) else $error("channel a not cut");
  // closed input b releases channel b
  property p_rel_b;
    @(posedge clk_sys) disable iff (sys_rst) sync2[0] |=> closed[0];
  endproperty
  a_rel_b: assert property (p_rel_b) else $error("channel b not released");
  property p_filt;
    @(posedge clk_sys) disable iff (sys_rst) ($fell(sync2[1]) && closed[1]) |=> closed[1] [*8];
  endproperty
  a_filt: assert property (p_filt) else $error("short pulse passed");
  property p_alarm;
    @(posedge clk_sys) disable iff (sys_rst)
      (state == dctom_pkg::DCTOM_RUN && any_cut && motor_running) |=> cutoff_timing_alarm && alarm_code == 8'h3F;
  endproperty
  a_alarm: assert property (p_alarm) else $error("timing alarm missing");
  // input b open long enough cuts channel b
  property p_cut_b;
    @(posedge clk_sys) disable iff (sys_rst) (g_chk[0].open_run == FILT_MAX && !sync2[0]) |=> !closed[0];
  endproperty
  a_cut_b: assert property (p_cut_b) else $error("channel b not cut");
  // closed input a releases channel a
  property p_rel_a;
    @(posedge clk_sys) disable iff (sys_rst) sync2[1] |=> closed[1];
  endproperty
  a_rel_a: assert property (p_rel_a) else $error("channel a not released");
  // both closed from cutoff releases drive
  property p_drive_on;
    @(posedge clk_sys) disable iff (sys_rst) (state == dctom_pkg::DCTOM_CUT && !any_cut) |=> base_drive_enable;
  endproperty
  a_drive_on: assert property (p_drive_on) else $error("drive not released");
  property p_brake;
    @(posedge clk_sys) disable iff (sys_rst)
      (state == dctom_pkg::DCTOM_RUN && any_cut && motor_running) |=> dynamic_brake;
  endproperty
  a_brake: assert property (p_brake) else $error("dynamic brake missing");
  property p_alarm_hold;
    @(posedge clk_sys) disable iff (sys_rst) (cutoff_timing_alarm && !alarm_clear) |=> cutoff_timing_alarm;
  endproperty
  a_alarm_hold: assert property (p_alarm_hold) else $error("timing alarm dropped");
endmodule : dctom_monitor

//--- testbench/dctom_relay.sv
`timescale 1ns/10ps
module dctom_relay #(
  parameter int PMAX = 19
) (
  // clock
  input wire logic clk_sys,
  // wanted contact levels and test pulse length
  input wire logic [1:0] want,
  input wire logic [7:0] tp,
  // contacts, high means closed
  output logic [1:0] sin
);
  logic [7:0] cnt = 8'h00;
  always @(posedge clk_sys) begin
    if (tp != 8'h00) begin
      cnt <= (tp > 8'(PMAX)) ? 8'(PMAX) : tp;
    end else if (cnt != 8'h00) begin
      cnt <= cnt - 8'h01;
    end
  end
  assign sin = (cnt != 8'h00) ? 2'h0 : want;
endmodule : dctom_relay

//--- testbench/dctom_monitor_tb.sv
`timescale 1ns/10ps
module dctom_monitor_tb;
  localparam int F = 20;
  logic clk_sys;
  logic sys_rst;
  logic mr;
  logic ac;
  logic [1:0] want;
  logic [1:0] sin;
  logic [7:0] tp;
  logic [7:0] code;
  logic ma, mb, mab, base, brk, alm;
  logic [9:0] mv, av, mvl, avl;
  logic [9:0] mq[$], aq[$];
  int n_mismatch = 0, checks_done = 0;
  logic [31:0] rs;
  initial clk_sys = 1'h0;
  always #20 clk_sys = ~clk_sys;
  dctom_relay #(.PMAX(F - 1)) rel (.clk_sys(clk_sys), .want(want), .tp(tp), .sin(sin));
  dctom_monitor #(.FILT_CYCLES(F)) dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .safety_input_a(sin[1]),
    .safety_input_b(sin[0]), .motor_running(mr), .alarm_clear(ac), .cutoff_monitor_a(ma),
    .cutoff_monitor_b(mb), .cutoff_monitor_both(mab), .base_drive_enable(base),
    .dynamic_brake(brk), .cutoff_timing_alarm(alm), .alarm_code(code));
  assign mv = {6'h00, ma, mb, mab, base};
  assign av = {alm, brk, code};
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction : xs
  task automatic cmp(input string n, input logic [9:0] e, input logic [9:0] s);
    checks_done++;
    if (s !== e || $isunknown(s)) begin
      n_mismatch++;
      $display("unexpected %s exp %h got %h", n, e, s);
    end
  endtask : cmp
  task automatic go(input logic [1:0] w);
    want <= w;
    repeat (F + 12) @(posedge clk_sys);
  endtask : go
  task automatic end_sim;
    if (mq.size() != 0 || aq.size() != 0) begin
      n_mismatch++;
      $display("unexpected pending notes exp %0d got %0d", 0, mq.size() + aq.size());
    end
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim
  // each change of the outputs takes the oldest note
  always @(posedge clk_sys) begin
    mvl <= mv;
    avl <= av;
    if (!sys_rst && mv !== mvl) cmp("monitors", mq.size() ? mq.pop_front() : ~mv, mv);
    if (!sys_rst && av !== avl) cmp("alarm", aq.size() ? aq.pop_front() : ~av, av);
  end
  initial begin
    rs = 32'hD990EBC7;
    sys_rst <= 1'h1;
    mr <= 1'h0;
    ac <= 1'h0;
    want <= 2'h0;
    tp <= 8'h00;
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'h0;
    @(posedge clk_sys);
    #1 cmp("reset", 10'h00E, mv);
    @(posedge clk_sys);
    mq.push_back(10'h001);
    go(2'h3);
    // short off pulses must leave the outputs alone
    for (int i = 0; i < 6; i++) begin
      rs = xs(rs);
      tp <= 8'(rs % 32'(F - 1)) + 8'h01;
      // motor state and alarm clear do nothing while both channels stay released
      mr <= rs[8];
      ac <= rs[9];
      @(posedge clk_sys);
      tp <= 8'h00;
      repeat (F + 10) @(posedge clk_sys);
    end
    mr <= 1'h0;
    ac <= 1'h0;
    // one channel alone, on purpose
    mq.push_back(10'h008);
    go(2'h1);
    mq.push_back(10'h001);
    go(2'h3);
    mq.push_back(10'h004);
    go(2'h2);
    mq.push_back(10'h001);
    go(2'h3);
    mq.push_back(10'h00E);
    go(2'h0);
    mq.push_back(10'h001);
    go(2'h3);
    mr <= 1'h1;
    mq.push_back(10'h00E);
    aq.push_back(10'h33F);
    go(2'h0);
    aq.push_back(10'h23F);
    mr <= 1'h0;
    ac <= 1'h1;
    repeat (F) @(posedge clk_sys);
    aq.push_back(10'h000);
    mq.push_back(10'h001);
    go(2'h3);
    ac <= 1'h0;
    end_sim();
  end
endmodule : dctom_monitor_tb
